// >>> smc_regs.svh
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH

// modulator control register location
`define SMC_CTRL_ADDR    8'h00
`define SMC_CTRL_WORD    6'h00

// field positions inside the control byte
`define SMC_BIT_ENABLE   7
`define SMC_BIT_OE       6
`define SMC_BIT_SLEW     5
`define SMC_BIT_POL      4
`define SMC_BIT_OUTVAL   3
`define SMC_BIT_SWBIT    0

// reset value and access masks
`define SMC_CTRL_RESET   8'h20
`define SMC_CTRL_WMASK   8'hF1
`define SMC_CTRL_RMASK   8'hF9

`endif

// >>> smc_pkg.sv
`include "smc_regs.svh"

package smc_pkg;

    typedef logic [7:0]  smc_addr_t;
    typedef logic [31:0] smc_data_t;
    typedef logic [3:0]  smc_sel_t;

    typedef enum logic [0:0] {
        SMC_ST_IDLE = 1'b0,
        SMC_ST_ACK  = 1'b1
    } smc_bus_state_t;

    function automatic logic smc_addr_hit(input smc_addr_t adr);
        return adr[7:2] == `SMC_CTRL_WORD;
    endfunction

endpackage

// >>> smc_wb_slave.sv
`timescale 1ns/1ns

module smc_wb_slave (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic cyc_i,
    input  wire logic stb_i,
    output logic      ack_o,
    output logic      take_o,
    output logic      commit_o
);
    import smc_pkg::*;

    smc_bus_state_t state_r;
    smc_bus_state_t state_nxt;

    // take: request seen in idle; commit: the edge where master samples ack
    assign take_o   = (state_r == SMC_ST_IDLE) && cyc_i && stb_i;
    assign commit_o = (state_r == SMC_ST_ACK) && cyc_i && stb_i;
    assign ack_o    = (state_r == SMC_ST_ACK);

    always_comb begin
        case (state_r)
            SMC_ST_IDLE: state_nxt = take_o ? SMC_ST_ACK : SMC_ST_IDLE;
            SMC_ST_ACK:  state_nxt = SMC_ST_IDLE;
            default:     state_nxt = SMC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= SMC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

endmodule

// >>> smc_mixer.sv
`timescale 1ns/1ns

module smc_mixer (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic modulator_enable_i,
    input  wire logic carrier_high_i,
    input  wire logic carrier_low_i,
    input  wire logic modulator_src_i,
    input  wire logic sw_bit_selected_i,
    input  wire logic software_modulator_bit_i,
    output logic      mix_o
);
    logic carrier_high_g;
    logic carrier_low_g;
    logic modulator_g;
    logic mix_nxt;
    logic mix_r;

    // disabled: carriers grounded, modulator taken from the software bit
    assign carrier_high_g = modulator_enable_i & carrier_high_i;
    assign carrier_low_g  = modulator_enable_i & carrier_low_i;
    assign modulator_g    = (modulator_enable_i & ~sw_bit_selected_i) ?
                            modulator_src_i : software_modulator_bit_i;

    // high carrier while modulator high, low carrier while it is low
    assign mix_nxt = (modulator_g & carrier_high_g) |
                     (~modulator_g & carrier_low_g);
    assign mix_o   = mix_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mix_r <= 1'b0;
        end else begin
            mix_r <= mix_nxt;
        end
    end

endmodule

// >>> smc_top.sv
`timescale 1ns/1ns
`include "smc_regs.svh"

module smc_top (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            wb_cyc_i,
    input  wire logic            wb_stb_i,
    input  wire logic            wb_we_i,
    input  wire smc_pkg::smc_addr_t wb_adr_i,
    input  wire smc_pkg::smc_sel_t  wb_sel_i,
    input  wire smc_pkg::smc_data_t wb_dat_i,
    output smc_pkg::smc_data_t   wb_dat_o,
    output logic                 wb_ack_o,
    input  wire logic            carrier_high_i,
    input  wire logic            carrier_low_i,
    input  wire logic            modulator_src_i,
    input  wire logic            sw_bit_selected_i,
    output logic                 modulated_pin_o,
    output logic                 output_slew_limit_o,
    output logic                 modulator_active_o
);
    import smc_pkg::*;

    // control fields
    logic      modulator_enable_r;
    logic      modulated_pin_output_enable_r;
    logic      output_slew_limit_r;
    logic      output_polarity_invert_r;
    logic      software_modulator_bit_r;
    logic      modulated_output_value_r;
    logic      pin_r;
    smc_data_t rdata_r;

    // bus decode
    logic      bus_take;
    logic      bus_commit;
    logic      bus_ack;
    logic      addr_hit;
    logic      ctrl_write;
    logic [7:0] wbyte;
    logic [7:0] ctrl_read;
    smc_data_t rdata_nxt;

    // datapath
    logic      mix_w;
    logic      out_value_nxt;
    logic      pin_nxt;

    smc_wb_slave u_slave (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .cyc_i    (wb_cyc_i),
        .stb_i    (wb_stb_i),
        .ack_o    (bus_ack),
        .take_o   (bus_take),
        .commit_o (bus_commit)
    );

    smc_mixer u_mixer (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .modulator_enable_i       (modulator_enable_r),
        .carrier_high_i           (carrier_high_i),
        .carrier_low_i            (carrier_low_i),
        .modulator_src_i          (modulator_src_i),
        .sw_bit_selected_i        (sw_bit_selected_i),
        .software_modulator_bit_i (software_modulator_bit_r),
        .mix_o                    (mix_w)
    );

    assign addr_hit   = smc_addr_hit(wb_adr_i);
    // write lands on the edge where the master samples ack
    assign ctrl_write = bus_commit && wb_we_i && addr_hit && wb_sel_i[0];
    assign wbyte      = wb_dat_i[7:0];

    // unimplemented bits 2-1 forced to zero, upper bits zero
    assign ctrl_read = {modulator_enable_r,
                        modulated_pin_output_enable_r,
                        output_slew_limit_r,
                        output_polarity_invert_r,
                        modulated_output_value_r,
                        2'b00,
                        software_modulator_bit_r} & `SMC_CTRL_RMASK;
    assign rdata_nxt = (addr_hit && !wb_we_i) ? {24'h000000, ctrl_read} : 32'h00000000;

    // status view of the modulator output, polarity applied
    assign out_value_nxt = mix_w ^ output_polarity_invert_r;
    // pin held low while output enable is clear
    assign pin_nxt = modulated_pin_output_enable_r & out_value_nxt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            modulator_enable_r            <= 1'b0;
            modulated_pin_output_enable_r <= 1'b0;
            output_slew_limit_r           <= 1'b1;
            output_polarity_invert_r      <= 1'b0;
            software_modulator_bit_r      <= 1'b0;
        end else if (ctrl_write) begin
            // bits 3, 2, 1 are never stored from the bus
            modulator_enable_r            <= wbyte[`SMC_BIT_ENABLE];
            modulated_pin_output_enable_r <= wbyte[`SMC_BIT_OE];
            output_slew_limit_r           <= wbyte[`SMC_BIT_SLEW];
            output_polarity_invert_r      <= wbyte[`SMC_BIT_POL];
            software_modulator_bit_r      <= wbyte[`SMC_BIT_SWBIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            modulated_output_value_r <= 1'b0;
            pin_r                    <= 1'b0;
        end else begin
            modulated_output_value_r <= out_value_nxt;
            pin_r                    <= pin_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h00000000;
        end else if (bus_take) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign wb_dat_o            = rdata_r;
    assign wb_ack_o            = bus_ack;
    assign modulated_pin_o     = pin_r;
    assign output_slew_limit_o = output_slew_limit_r;
    assign modulator_active_o  = modulator_enable_r;

    // checks

    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    a_reset_disables: assert property (
        $past(rst_i) |-> !modulator_active_o && !modulated_pin_o && !mix_w
    ) else $error("modulator not disabled after reset");

    a_reset_defaults: assert property (
        $past(rst_i) |-> ctrl_read == `SMC_CTRL_RESET && output_slew_limit_o
    ) else $error("control bits not at reset defaults");

    a_readback_tracks: assert property (
        !$past(rst_i) |->
            modulated_output_value_r == ($past(mix_w) ^ $past(output_polarity_invert_r))
    ) else $error("readback bit does not follow modulator output");

    a_readback_lag: assert property (
        $changed(mix_w) && $stable(output_polarity_invert_r) |=>
            $changed(modulated_output_value_r)
    ) else $error("readback bit missed a sampled output change");

    a_unimpl_zero: assert property (
        wb_ack_o |-> wb_dat_o[2:1] == 2'b00 && wb_dat_o[31:8] == 24'h000000
    ) else $error("unimplemented bits read nonzero");

    sequence s_ctrl_write;
        bus_commit && wb_we_i && addr_hit && wb_sel_i[0];
    endsequence

    sequence s_ctrl_read_req;
        bus_take && !wb_we_i && addr_hit;
    endsequence

    a_sw_bit_write: assert property (
        s_ctrl_write |=>
            software_modulator_bit_r == $past(wb_dat_i[0]) &&
            modulator_enable_r == $past(wb_dat_i[7])
    ) else $error("writable control bits not stored");

    a_read_value: assert property (
        s_ctrl_read_req |=> wb_ack_o && wb_dat_o[3] == $past(modulated_output_value_r)
    ) else $error("read data does not show output readback");

    sequence s_mod_from_source;
        modulator_enable_r && !sw_bit_selected_i;
    endsequence

    a_mix_high: assert property (
        s_mod_from_source and modulator_src_i |=> mix_w == $past(carrier_high_i)
    ) else $error("high carrier not mixed while modulator high");

    a_mix_low: assert property (
        s_mod_from_source and !modulator_src_i |=> mix_w == $past(carrier_low_i)
    ) else $error("low carrier not mixed while modulator low");

    a_pin_low_off: assert property (
        !modulated_pin_output_enable_r |=> !modulated_pin_o
    ) else $error("pin driven while output disabled");

    a_pin_polarity: assert property (
        modulated_pin_output_enable_r |=>
            modulated_pin_o == ($past(mix_w) ^ $past(output_polarity_invert_r))
    ) else $error("pin value not mix xor polarity");

    sequence s_disabled_two;
        !modulator_enable_r ##1 !modulator_enable_r;
    endsequence

    a_disabled_pin: assert property (
        s_disabled_two |=>
            modulated_pin_o ==
            ($past(modulated_pin_output_enable_r) & $past(output_polarity_invert_r))
    ) else $error("disabled modulator still mixes carriers");

    a_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o
    ) else $error("ack held longer than one cycle");

    a_ack_after_take: assert property (
        bus_take |=> wb_ack_o
    ) else $error("request not acknowledged in the next cycle");

    a_ack_needs_take: assert property (
        !bus_take |=> !wb_ack_o
    ) else $error("ack without a taken request");

    a_take_no_write: assert property (
        bus_take |=> $stable(modulator_enable_r) && $stable(software_modulator_bit_r)
    ) else $error("write landed before the ack cycle");

    a_write_at_ack: assert property (
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && addr_hit && wb_sel_i[0] |=>
            software_modulator_bit_r == $past(wb_dat_i[0])
    ) else $error("write not stored at the ack edge");

    a_rdata_hold: assert property (
        !bus_take |=> $stable(wb_dat_o)
    ) else $error("read data changed without a request");

    a_unmapped_zero: assert property (
        bus_take && !addr_hit |=> wb_dat_o == 32'h00000000
    ) else $error("unmapped read returned data");

    a_ctrl_hold: assert property (
        !ctrl_write |=> $stable(software_modulator_bit_r) && $stable(modulator_enable_r) &&
            $stable(modulated_pin_output_enable_r) && $stable(output_polarity_invert_r) &&
            $stable(output_slew_limit_r)
    ) else $error("control bits changed without a write");

    a_oe_write: assert property (
        s_ctrl_write |=> modulated_pin_output_enable_r == $past(wb_dat_i[6])
    ) else $error("output enable bit not stored");

    a_pol_write: assert property (
        s_ctrl_write |=> output_polarity_invert_r == $past(wb_dat_i[4])
    ) else $error("polarity bit not stored");

    a_slew_write: assert property (
        s_ctrl_write |=> output_slew_limit_o == $past(wb_dat_i[5])
    ) else $error("slew limit bit not stored");

    a_enable_output: assert property (
        s_ctrl_write |=> modulator_active_o == $past(wb_dat_i[7])
    ) else $error("enable output does not follow the written bit");

    a_bit3_readonly: assert property (
        ctrl_write |=>
            modulated_output_value_r == ($past(mix_w) ^ $past(output_polarity_invert_r))
    ) else $error("write disturbed the readback bit");

    a_read_fields: assert property (
        s_ctrl_read_req |=> wb_dat_o[0] == $past(software_modulator_bit_r) &&
            wb_dat_o[7:4] == $past({modulator_enable_r, modulated_pin_output_enable_r,
                                    output_slew_limit_r, output_polarity_invert_r})
    ) else $error("read data does not show the control fields");

    a_disabled_mix_zero: assert property (
        !modulator_enable_r |=> !mix_w
    ) else $error("carriers not grounded while disabled");

    a_sw_mod_high: assert property (
        modulator_enable_r && sw_bit_selected_i && software_modulator_bit_r |=>
            mix_w == $past(carrier_high_i)
    ) else $error("software bit high did not select the high carrier");

    a_sw_mod_low: assert property (
        modulator_enable_r && sw_bit_selected_i && !software_modulator_bit_r |=>
            mix_w == $past(carrier_low_i)
    ) else $error("software bit low did not select the low carrier");

    a_mix_runs_oe_off: assert property (
        modulator_enable_r && !modulated_pin_output_enable_r && !sw_bit_selected_i &&
            modulator_src_i |=> mix_w == $past(carrier_high_i)
    ) else $error("mixer stopped while output disabled");

endmodule

// >>> smc_pin_model.sv
`timescale 1ns/1ns

// receiver side of the modulated pin: counts rising edges it sees
module smc_pin_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       pin_i,
    input  wire logic       slew_limit_i,
    output logic [15:0]     edges_o,
    output logic            level_o
);
    logic pin_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_r   <= 1'b0;
            edges_o <= 16'h0000;
        end else begin
            pin_r <= pin_i;
            if (pin_i && !pin_r) begin
                edges_o <= edges_o + 16'h0001;
            end
        end
    end

    // slew setting only shapes the analogue edge, level is unaffected
    assign level_o = pin_r | (1'b0 & slew_limit_i);
endmodule

// >>> testbench.sv
`timescale 1ns/1ns

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end

module testbench;
    import smc_pkg::*;

    logic       clk_i, rst_i, cyc, stb, we, ch, cl, md, sw;
    smc_addr_t  adr;
    smc_sel_t   sel;
    smc_data_t  dat, wb_dat_o, q;
    logic       wb_ack_o, modulated_pin_o, output_slew_limit_o, modulator_active_o;
    logic       lvl;
    logic [15:0] edges, e0;
    int         failures, comparisons, cycles;
    logic [13:0] r;
    // ctl, carrier high, carrier low, modulator, sw select, pin, readback
    logic [13:0] rows [9] = '{{8'hC0, 4'b1010, 2'b11}, {8'hC0, 4'b1000, 2'b00},
        {8'hC0, 4'b0100, 2'b11}, {8'hD0, 4'b1010, 2'b00}, {8'h80, 4'b1110, 2'b01},
        {8'h50, 4'b1110, 2'b11}, {8'hC1, 4'b1001, 2'b11}, {8'hC0, 4'b1011, 2'b00},
        {8'hFF, 4'b1010, 2'b00}};

    smc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .carrier_high_i(ch),
        .carrier_low_i(cl), .modulator_src_i(md), .sw_bit_selected_i(sw),
        .modulated_pin_o(modulated_pin_o), .output_slew_limit_o(output_slew_limit_o),
        .modulator_active_o(modulator_active_o));

    smc_pin_model PIN (.clk_i(clk_i), .rst_i(rst_i), .pin_i(modulated_pin_o),
        .slew_limit_i(output_slew_limit_o), .edges_o(edges), .level_o(lvl));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic wb(input logic w, input smc_addr_t a, input smc_sel_t s,
                      input smc_data_t d, output smc_data_t rd);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("active", 1'b0, modulator_active_o)
        `CHK("slew", 1'b1, output_slew_limit_o)
        `CHK("pin", 1'b0, modulated_pin_o)
        wb(1'b0, 8'h00, 4'h1, 32'h0, q);
        `CHK("ctrl", 32'h20, q)
    endtask

    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
        dat = 32'h0; ch = 1'b0; cl = 1'b0; md = 1'b0; sw = 1'b0;
        failures = 0; comparisons = 0; cycles = 0;
        do_reset();
        $display("reset test done");
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk_i);
            ch <= r[5]; cl <= r[4]; md <= r[3]; sw <= r[2];
            wb(1'b1, 8'h00, 4'h1, {24'h0, r[13:6]}, q);
            repeat (4) @(posedge clk_i);
            `CHK("pin", r[1], modulated_pin_o)
            `CHK("level", r[1], lvl)
            `CHK("slew", r[11], output_slew_limit_o)
            `CHK("active", r[13], modulator_active_o)
            wb(1'b0, 8'h00, 4'h1, 32'h0, q);
            `CHK("ctrl", {24'h0, r[13:6] & 8'hF1 | {4'h0, r[0], 3'h0}}, q)
            $display("row %0d done", i);
        end
        // unmapped place and a write with the byte lane off
        wb(1'b1, 8'h04, 4'h1, 32'h00, q);
        wb(1'b0, 8'h04, 4'h1, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        wb(1'b1, 8'h00, 4'h0, 32'h00, q);
        wb(1'b0, 8'h00, 4'h1, 32'h0, q);
        `CHK("ctrl", 32'hF1, q)
        $display("awkward test done");
        // reset in mid-run while enabled and driving
        e0 = edges;
        wb(1'b1, 8'h00, 4'h1, 32'hC1, q);
        repeat (3) @(posedge clk_i);
        `CHK("pin", 1'b1, modulated_pin_o)
        `CHK("edges", e0 + 16'h0001, edges)
        do_reset();
        $display("midrun reset test done");
        tally_and_finish();
    end
endmodule
